// *** core/tpb_bus_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface tpb_bus_if;
  // phases: phase one capture, phase two strobes valid
  logic       phase_one_clock;
  logic       phase_two_clock;
  // strobes, active low, one shared enable
  logic       load_address_strobe_n;
  logic       read_strobe_n;
  logic       write_strobe_n;
  logic       strobe_oe;
  // data bus, processor and peripheral drivers
  logic [7:0] cpu_data;
  logic       cpu_data_oe;
  logic [7:0] per_data;
  logic       per_data_oe;
  // interrupt request, open drain, low when peripheral pulls
  logic       interrupt_request_oe;
  logic       halt_n;

  modport cpu (
    output phase_one_clock, phase_two_clock,
    output load_address_strobe_n, read_strobe_n, write_strobe_n,
    output strobe_oe, cpu_data, cpu_data_oe,
    input  per_data, per_data_oe, interrupt_request_oe, halt_n
  );
  modport per (
    input  phase_one_clock, phase_two_clock,
    input  load_address_strobe_n, read_strobe_n, write_strobe_n,
    input  strobe_oe, cpu_data, cpu_data_oe,
    output per_data, per_data_oe, interrupt_request_oe
  );
endinterface
`default_nettype wire

// *** core/tpb_cpu_end.sv ***
//  Function
// RULE_01 - strobes low true, high false
// RULE_02 - strobes valid and decoded in phase two
// RULE_03 - all high: nop, bus floats
// RULE_04 - write only: peripheral stores on phase one
// RULE_05 - read only: peripheral drives addressed byte
// RULE_06 - halt low: grant, then float lines
// RULE_07 - load only: all chips capture address byte
// RULE_08 - load with write never issued
// RULE_09 - load while reading: sender drives, all load
// RULE_10 - all low: interrupter drives vector
// RULE_11 - processor drives strobes unless granted away
// RULE_12 - address sent low byte then high
// RULE_13 - load strobe held phase one through two
// RULE_14 - address byte driven phase two, taken one
// RULE_15 - peripherals hold address awaiting next strobe
// RULE_16 - read strobe phase one through two
// RULE_17 - consecutive reads increment after phase one
// RULE_18 - write increments address pointer
// RULE_19 - peripheral drives only when addressed, else off
`timescale 1ns/1ps
`default_nettype none
`include "tpb_defs.svh"
module tpb_cpu_end
  import tpb_pkg::*;
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  // user request
  input  wire logic        i_req_valid,
  input  wire logic [2:0]  i_req_op,
  input  wire logic [15:0] i_req_addr,
  input  wire logic        i_req_new_addr,
  input  wire logic [7:0]  i_req_wdata,
  output logic             o_req_ready,
  // answer
  output logic             o_rsp_valid,
  output logic [7:0]       o_rsp_data,
  output logic             o_irq_pending,
  output logic             o_granted,
  // bus
  tpb_bus_if.cpu           bus
);
  tpb_state_e state;
  tpb_cycle_e cur_op;
  logic       phase;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        take;
  logic        grant_done;
  tpb_cycle_e  req_cycle;

  // ---------------------------------------------------------------
  // two phase clock: phase one then phase two
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end
  assign bus.phase_one_clock = ~phase;
  assign bus.phase_two_clock = phase;

  // ---------------------------------------------------------------
  // status, ready only in idle phase two with no halt or interrupt
  // ---------------------------------------------------------------
  assign o_irq_pending = bus.interrupt_request_oe;
  assign o_req_ready   = (state == TPB_S_IDLE) && phase && bus.halt_n &&
                         !bus.interrupt_request_oe;
  assign o_granted     = (state == TPB_S_HALT);
  assign take          = o_req_ready && i_req_valid;

  // ---------------------------------------------------------------
  // request latch, only legal cycles are kept
  // ---------------------------------------------------------------
  always_comb begin
    req_cycle = TPB_NOP;
    case (i_req_op)
      `TPB_CODE_WRITE: req_cycle = TPB_WRITE;
      `TPB_CODE_READ:  req_cycle = TPB_READ;
      `TPB_CODE_LMRD:  req_cycle = TPB_LMRD;
      default:         req_cycle = TPB_NOP; // RULE_08
    endcase
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cur_op <= TPB_NOP;
      addr   <= `TPB_ADDR_RST;
      wdata  <= `TPB_BYTE_ZERO;
    end else if (take) begin
      cur_op <= req_cycle;
      addr   <= i_req_addr;
      wdata  <= i_req_wdata;
    end
  end

  // ---------------------------------------------------------------
  // sequencer, moves at end of phase two
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state  <= TPB_S_IDLE;
    end else if (phase) begin
      case (state)
        TPB_S_IDLE: begin
          if (!bus.halt_n) begin
            state <= TPB_S_HALT; // RULE_06
          end else if (bus.interrupt_request_oe) begin
            state <= TPB_S_IACK; // RULE_10
          end else if (i_req_valid) begin
            state  <= i_req_new_addr ? TPB_S_ADLO : TPB_S_DATA;
          end
        end
        TPB_S_ADLO: state <= TPB_S_ADHI; // RULE_12
        TPB_S_ADHI: state <= TPB_S_DATA;
        TPB_S_DATA: state <= TPB_S_IDLE;
        TPB_S_IACK: state <= TPB_S_ACKHI;
        TPB_S_ACKHI: state <= TPB_S_IDLE;
        TPB_S_HALT: begin
          if (bus.halt_n) begin
            state <= TPB_S_IDLE;
          end
        end
        default: state <= TPB_S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // strobe and data drive
  // ---------------------------------------------------------------
  logic [2:0] code;
  always_comb begin
    code = `TPB_CODE_NOP; // RULE_03
    case (state)
      TPB_S_ADLO, TPB_S_ADHI, TPB_S_ACKHI: code = `TPB_CODE_LOAD; // RULE_13
      TPB_S_DATA: begin
        if (cur_op == TPB_WRITE || cur_op == TPB_READ ||
            cur_op == TPB_LMRD) begin
          code = cur_op; // RULE_08
        end
      end
      TPB_S_IACK: code = `TPB_CODE_IACK;
      TPB_S_HALT: code = `TPB_CODE_DMA; // RULE_06
      default: code = `TPB_CODE_NOP;
    endcase
  end
  assign bus.load_address_strobe_n = code[2];
  assign bus.read_strobe_n         = code[1];
  assign bus.write_strobe_n        = code[0];
  // granted: strobes floated after the grant cycle
  assign bus.strobe_oe = !(state == TPB_S_HALT && grant_done); // RULE_11

  // ---------------------------------------------------------------
  // grant stands one full bus cycle, then lines float
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      grant_done <= 1'b0;
    end else begin
      grant_done <= (state == TPB_S_HALT) && (grant_done || phase); // RULE_06
    end
  end

  always_comb begin
    bus.cpu_data    = `TPB_BYTE_ZERO;
    bus.cpu_data_oe = 1'b0;
    if (phase) begin
      case (state)
        TPB_S_ADLO: begin
          bus.cpu_data    = addr[`TPB_LO_MSB:0]; // RULE_14
          bus.cpu_data_oe = 1'b1;
        end
        TPB_S_ADHI: begin
          bus.cpu_data    = addr[`TPB_HI_MSB:`TPB_HI_LSB];
          bus.cpu_data_oe = 1'b1;
        end
        TPB_S_ACKHI: begin
          bus.cpu_data_oe = 1'b1;
        end
        TPB_S_DATA: begin
          bus.cpu_data    = wdata;
          bus.cpu_data_oe = (cur_op == TPB_WRITE);
        end
        default: bus.cpu_data_oe = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read capture on phase two end
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rsp_valid <= 1'b0;
      o_rsp_data  <= `TPB_BYTE_ZERO;
    end else begin
      o_rsp_valid <= 1'b0;
      if (phase && state == TPB_S_DATA &&
          (cur_op == TPB_READ || cur_op == TPB_LMRD)) begin
        o_rsp_valid <= 1'b1; // RULE_16
        o_rsp_data  <= bus.per_data;
      end
    end
  end
endmodule // tpb_cpu_end
`default_nettype wire

// *** core/tpb_cycle_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tpb_defs.svh"
module tpb_cycle_decode
  import tpb_pkg::*;
(
  // strobes
  input  wire logic load_address_strobe_n,
  input  wire logic read_strobe_n,
  input  wire logic write_strobe_n,
  // decoded cycle
  output tpb_cycle_e o_cycle
);
  // low level means true
  assign o_cycle = tpb_cycle_e'({load_address_strobe_n, read_strobe_n,
                                 write_strobe_n}); // RULE_01
endmodule // tpb_cycle_decode
`default_nettype wire

// *** core/tpb_defs.svh ***
`ifndef TPB_DEFS_SVH
`define TPB_DEFS_SVH
// strobe levels, active low
`define TPB_ASSERTED   1'b0
`define TPB_RELEASED   1'b1
// cycle codes {load_address, read, write}
`define TPB_CODE_NOP   3'h7
`define TPB_CODE_WRITE 3'h6
`define TPB_CODE_READ  3'h5
`define TPB_CODE_DMA   3'h4
`define TPB_CODE_LOAD  3'h3
`define TPB_CODE_ILLEG 3'h2
`define TPB_CODE_LMRD  3'h1
`define TPB_CODE_IACK  3'h0
// address layout
`define TPB_ADDR_RST   16'h0000
`define TPB_ADDR_ONE   16'h0001
`define TPB_BYTE_ZERO  8'h00
`define TPB_LO_MSB     7
`define TPB_HI_LSB     8
`define TPB_HI_MSB     15
`endif

// *** core/tpb_per_end.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tpb_defs.svh"
module tpb_per_end
  import tpb_pkg::*;
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  // user side memory
  input  wire logic [7:0]  i_rdata,
  input  wire logic        i_int_req,
  input  wire logic [7:0]  i_vector,
  output logic [15:0]      o_addr,
  output logic             o_wr_pulse,
  output logic [7:0]       o_wdata,
  // bus
  tpb_bus_if.per           bus
);
  tpb_cycle_e cycle;
  logic       lo_next;
  logic       ack_seen;

  tpb_cycle_decode u_decode (
    .load_address_strobe_n (bus.load_address_strobe_n),
    .read_strobe_n         (bus.read_strobe_n),
    .write_strobe_n        (bus.write_strobe_n),
    .o_cycle               (cycle)
  );

  // decode only while phase two shows valid strobes
  wire logic act = bus.phase_two_clock && bus.strobe_oe; // RULE_02
  wire logic [7:0] bus_byte = bus.cpu_data_oe ? bus.cpu_data : bus.per_data;

  // ---------------------------------------------------------------
  // address register and writes, taken at phase two end
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_addr     <= `TPB_ADDR_RST;
      lo_next    <= 1'b1;
      o_wr_pulse <= 1'b0;
      o_wdata    <= `TPB_BYTE_ZERO;
    end else begin
      o_wr_pulse <= 1'b0;
      // step on after the stored byte left with its address
      if (o_wr_pulse) begin
        o_addr <= o_addr + `TPB_ADDR_ONE; // RULE_18
      end
      if (act) begin
        case (cycle)
          TPB_LOAD, TPB_LMRD, TPB_IACK: begin // RULE_10
            if (lo_next) begin
              o_addr[`TPB_LO_MSB:0] <= bus_byte; // RULE_07
            end else begin
              o_addr[`TPB_HI_MSB:`TPB_HI_LSB] <= bus_byte; // RULE_09
            end
            lo_next <= ~lo_next; // RULE_12
          end
          TPB_READ: o_addr <= o_addr + `TPB_ADDR_ONE; // RULE_17
          TPB_WRITE: begin
            o_wr_pulse <= 1'b1; // RULE_04
            o_wdata    <= bus.cpu_data;
          end
          default: o_addr <= o_addr; // RULE_15
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt request held until acknowledged
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_seen <= 1'b0;
    end else begin
      ack_seen <= act && cycle == TPB_IACK;
    end
  end
  assign bus.interrupt_request_oe = i_int_req && !ack_seen &&
                                    !(act && cycle == TPB_IACK);

  // ---------------------------------------------------------------
  // data drive, phase two only, off otherwise
  // ---------------------------------------------------------------
  always_comb begin
    bus.per_data    = `TPB_BYTE_ZERO;
    bus.per_data_oe = 1'b0; // RULE_03
    if (act) begin
      case (cycle)
        TPB_READ, TPB_LMRD: begin
          bus.per_data    = i_rdata; // RULE_05
          bus.per_data_oe = 1'b1; // RULE_19
        end
        TPB_IACK: begin
          bus.per_data    = i_vector; // RULE_10
          bus.per_data_oe = i_int_req;
        end
        default: bus.per_data_oe = 1'b0;
      endcase
    end
  end
endmodule // tpb_per_end
`default_nettype wire

// *** core/tpb_pkg.sv ***
package tpb_pkg;
  typedef enum logic [2:0] {
    TPB_NOP   = 3'h7,
    TPB_WRITE = 3'h6,
    TPB_READ  = 3'h5,
    TPB_DMA   = 3'h4,
    TPB_LOAD  = 3'h3,
    TPB_ILLEG = 3'h2,
    TPB_LMRD  = 3'h1,
    TPB_IACK  = 3'h0
  } tpb_cycle_e;

  // processor state, gray along idle->addr lo->addr hi->data
  typedef enum logic [2:0] {
    TPB_S_IDLE  = 3'b000,
    TPB_S_ADLO  = 3'b001,
    TPB_S_ADHI  = 3'b011,
    TPB_S_DATA  = 3'b010,
    TPB_S_IACK  = 3'b110,
    TPB_S_ACKHI = 3'b111,
    TPB_S_HALT  = 3'b101
  } tpb_state_e;
endpackage

// *** verification/tpb_bus_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpb_bus_sva (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // phases and strobes
  input wire logic phase_one_clock,
  input wire logic phase_two_clock,
  input wire logic load_address_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic strobe_oe,
  // drivers and halt
  input wire logic cpu_data_oe,
  input wire logic per_data_oe,
  input wire logic halt_n
);
  wire logic p1   = phase_one_clock;
  wire logic p2   = phase_two_clock;
  wire logic ld_n = load_address_strobe_n;
  wire logic rd_n = read_strobe_n;
  wire logic wr_n = write_strobe_n;
  wire logic oe   = strobe_oe;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);

  property p_excl; !(p1 && p2); endproperty
  a_excl: assert property (p_excl)
    else $error("phases overlap");
  property p_illeg; oe |-> !(!ld_n && rd_n && !wr_n); endproperty
  a_illeg: assert property (p_illeg)
    else $error("load with write issued");
  property p_nop; oe && ld_n && rd_n && wr_n |-> !cpu_data_oe && !per_data_oe;
  endproperty
  a_nop: assert property (p_nop)
    else $error("bus driven in idle");
  property p_per; per_data_oe |-> oe && !rd_n && !(ld_n && !wr_n); endproperty
  a_per: assert property (p_per)
    else $error("peripheral drives outside read");
  property p_ldh; oe && p1 && !ld_n && rd_n |=> !ld_n && p2; endproperty
  a_ldh: assert property (p_ldh)
    else $error("load strobe not held");
  property p_rdh; oe && p1 && !rd_n && wr_n |=> !rd_n && p2; endproperty
  a_rdh: assert property (p_rdh)
    else $error("read strobe not held");
  property p_adr; oe && p2 && !ld_n && rd_n |-> cpu_data_oe && !per_data_oe;
  endproperty
  a_adr: assert property (p_adr)
    else $error("address byte not driven");
  property p_ans;
    oe && p2 && !rd_n && (wr_n || !ld_n) |-> per_data_oe && !cpu_data_oe;
  endproperty
  a_ans: assert property (p_ans)
    else $error("peripheral answer missing");
  property p_grant;
    $fell(oe) |-> !halt_n && $past(ld_n && !rd_n && !wr_n);
  endproperty
  a_grant: assert property (p_grant)
    else $error("strobes floated without grant");
  property p_float; !oe && !halt_n |=> !oe; endproperty
  a_float: assert property (p_float)
    else $error("strobes driven again while granted");
endmodule // tpb_bus_sva
`default_nettype wire

// *** verification/two_phase_bus_control_port_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module two_phase_bus_control_port_tb_top;
  logic        i_clock;
  logic        i_nrst;
  logic        i_req_valid;
  logic [2:0]  i_req_op;
  logic [15:0] i_req_addr;
  logic        i_req_new_addr;
  logic [7:0]  i_req_wdata;
  logic        o_req_ready;
  logic        o_rsp_valid;
  logic [7:0]  o_rsp_data;
  logic        o_irq_pending;
  logic        o_granted;
  logic [7:0]  i_rdata;
  logic        i_int_req;
  logic [7:0]  i_vector;
  logic [15:0] o_addr;
  logic        o_wr_pulse;
  logic [7:0]  o_wdata;
  logic [7:0]  mem [0:65535];
  int          n_errors;
  int          checked;
  int          cycles;

  tpb_bus_if bus ();
  tpb_cpu_end tpb_cpu_end_i (.i_clock, .i_nrst, .i_req_valid, .i_req_op,
    .i_req_addr, .i_req_new_addr, .i_req_wdata, .o_req_ready, .o_rsp_valid,
    .o_rsp_data, .o_irq_pending, .o_granted, .bus(bus));
  tpb_per_end tpb_per_end_i (.i_clock, .i_nrst, .i_rdata, .i_int_req,
    .i_vector, .o_addr, .o_wr_pulse, .o_wdata, .bus(bus));
  tpb_bus_sva tpb_bus_sva_i (.i_clock, .i_nrst,
    .phase_one_clock(bus.phase_one_clock),
    .phase_two_clock(bus.phase_two_clock),
    .load_address_strobe_n(bus.load_address_strobe_n),
    .read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
    .strobe_oe(bus.strobe_oe), .cpu_data_oe(bus.cpu_data_oe),
    .per_data_oe(bus.per_data_oe), .halt_n(bus.halt_n));

  // ------------------------------
  // user memory behind peripheral
  // ------------------------------
  assign i_rdata = mem[o_addr];
  always @(posedge i_clock) if (o_wr_pulse) mem[o_addr] <= o_wdata;
  always #5 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end

  // ------------------------------
  // tasks
  // ------------------------------
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic issue(input logic [2:0] op, input logic [15:0] a,
                       input logic nw, input logic [7:0] d);
    @(posedge i_clock);
    #1 i_req_op = op;
    i_req_addr = a;
    i_req_new_addr = nw;
    i_req_wdata = d;
    i_req_valid = 1'b1;
    do @(posedge i_clock); while (o_req_ready !== 1'b1);
    #1 i_req_valid = 1'b0;
  endtask
  task automatic read(input logic [15:0] a, input logic nw,
                      input logic [7:0] exp);
    issue(3'h5, a, nw, 8'h00);
    do @(posedge i_clock); while (o_rsp_valid !== 1'b1);
    chk16({8'h00, o_rsp_data}, {8'h00, exp});
  endtask
  task automatic complete_run();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ------------------------------
  // sequence
  // ------------------------------
  initial begin
    {i_clock, i_nrst, i_req_valid, i_req_new_addr, i_int_req} = 5'h00;
    {i_req_op, i_req_addr, i_req_wdata, i_vector} = 35'h0;
    {n_errors, checked, cycles} = 96'h0;
    bus.halt_n = 1'b1;
    foreach (mem[j]) mem[j] = 8'h00;
    mem[16'h0040] = 8'h78;
    mem[16'h0078] = 8'h01;
    repeat (10) @(posedge i_clock);
    #1 i_nrst = 1'b1;
    chk16(o_addr, 16'h0000);
    issue(3'h6, 16'h1234, 1'b1, 8'ha5);
    issue(3'h6, 16'h0000, 1'b0, 8'h5a);
    read(16'h1234, 1'b1, 8'ha5);
    read(16'h0000, 1'b0, 8'h5a);
    chk16(o_addr, 16'h1236);
    chk16({8'h00, mem[16'h1234]}, 16'h00a5);
    issue(3'h1, 16'h0040, 1'b1, 8'h00);
    do @(posedge i_clock); while (o_rsp_valid !== 1'b1);
    chk16({8'h00, o_rsp_data}, 16'h0078);
    chk16(o_addr, 16'h0078);
    issue(3'h1, 16'h0000, 1'b0, 8'h00);
    do @(posedge i_clock); while (o_rsp_valid !== 1'b1);
    chk16(o_addr, 16'h0178);
    i_vector = 8'h3c;
    i_int_req = 1'b1;
    do @(posedge i_clock); while (o_irq_pending !== 1'b1);
    chk1(o_req_ready, 1'b0);
    do @(posedge i_clock); while (o_irq_pending !== 1'b0);
    #1 i_int_req = 1'b0;
    do @(posedge i_clock); while (o_req_ready !== 1'b1);
    chk16(o_addr, 16'h003c);
    #1 bus.halt_n = 1'b0;
    do @(posedge i_clock); while (o_granted !== 1'b1);
    repeat (2) @(posedge i_clock);
    chk1(bus.strobe_oe, 1'b0);
    chk1(bus.cpu_data_oe, 1'b0);
    chk1(o_req_ready, 1'b0);
    #1 bus.halt_n = 1'b1;
    read(16'h1235, 1'b1, 8'h5a);
    complete_run();
  end
endmodule // two_phase_bus_control_port_tb_top
`default_nettype wire
